// file: design/pado_defs.svh
// named constants of the pipelined converter output stage
// assumes inclusion by the package and by each design file that needs a figure
`ifndef PADO_DEFS_SVH
`define PADO_DEFS_SVH

// ==========================================
// word and pipeline shape
`define PADO_RES_BITS 10
`define PADO_STAGES 9
`define PADO_DIGIT_BITS 2
`define PADO_STAMP_BITS 5

// ==========================================
// quantizer thresholds, full scale is 1024 codes
`define PADO_QTR_FS 10'h100
`define PADO_3QTR_FS 10'h300
`define PADO_HALF_FS 11'h200
`define PADO_FULL_FS 11'h400
`define PADO_FLASH_SHIFT 8
`define PADO_DIGIT_ZERO 2'h0
`define PADO_DIGIT_MID 2'h1
`define PADO_DIGIT_HIGH 2'h2

// ==========================================
// timing in convert half cycles: 6.5 cycles is 13 sub-clock edges
`define PADO_LAT_HALF_CYCLES 5'h0D

// ==========================================
// buffering and synchronisers
`define PADO_FIFO_DEPTH 4
`define PADO_SYNC_STAGES 3

`endif

// file: design/pado_pkg.sv
// types shared by the converter output stage
// assumes pado_defs.svh is on the include path
`include "pado_defs.svh"

package pado_pkg;

  // ==========================================
  // one pipeline slot: residue and aligned stage digits
  typedef struct packed {
    logic valid;
    logic [`PADO_STAMP_BITS-1:0] stamp;
    logic [`PADO_RES_BITS-1:0] sample;
    logic [`PADO_RES_BITS-1:0] resid;
    logic [`PADO_STAGES*`PADO_DIGIT_BITS-1:0] digits;
  } pado_slot_t;

  // ==========================================
  // corrected word waiting for its output edge
  typedef struct packed {
    logic [`PADO_STAMP_BITS-1:0] stamp;
    logic [`PADO_RES_BITS-1:0] code;
  } pado_word_t;

  // ==========================================
  // static pin configuration
  typedef struct packed {
    logic msb_flip;
    logic float_out;
  } pado_cfg_t;

endpackage : pado_pkg

// file: design/pado_sync.sv
// three flip-flop synchroniser with agreement filter
// assumes a single clock and the released reset of the top
`timescale 1ns/1ns
`default_nettype none
`include "pado_defs.svh"

module pado_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level
);

  // ==========================================
  // chain
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] level_ff;
  logic [WIDTH-1:0] nxt_level;

  initial
  begin
    if (WIDTH < 1)
      $error("pado_sync: WIDTH must be at least 1");
  end

  // a change counts only once stages two and three agree
  always_comb
  begin
    nxt_level = (s2_ff == s3_ff) ? s3_ff : level_ff;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_ff <= RESET_VAL;
      s2_ff <= RESET_VAL;
      s3_ff <= RESET_VAL;
      level_ff <= RESET_VAL;
    end
    else
    begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  assign level = level_ff;

endmodule : pado_sync
`default_nettype wire

// file: design/pado_fifo.sv
// flip-flop fifo with valid and ready on both sides
// assumes one clock; out_data is valid whenever out_valid is high
`timescale 1ns/1ns
`default_nettype none

module pado_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ==========================================
  // storage
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic [AW-1:0] nxt_wr;
  logic [AW-1:0] nxt_rd;
  logic [AW:0] nxt_cnt;
  logic push;
  logic pop;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("pado_fifo: DEPTH must be a power of two, at least 2");
  end

  always_comb
  begin
    in_ready = (cnt_ff != DEPTH[AW:0]);
    out_valid = (cnt_ff != '0);
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
    nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // data words need no reset
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_ff[wr_ff] <= in_data;
  end

  assign out_data = mem_ff[rd_ff];

  a_fifo_full: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cnt_ff == DEPTH[AW:0]) |-> !in_ready && !push)
    else $error("fifo accepted a word while full");

endmodule : pado_fifo
`default_nettype wire

// file: design/pado_top.sv
// digital side of a 10-bit pipelined sampling converter
// assumes capture logic drives the convert clock pin and latches data_out
// Summary of operation
// - word appears 6.5 convert cycles after sampling
// - non-overlapping track and hold phases per period
// - nine two-bit stages on double-rate sub-clock
// - per-stage delay lines align digits, then correction
// - coding select low gives straight offset binary
// - coding select high inverts the msb
// - float select high floats all data outputs
// - unconnected select pins read as low
`timescale 1ns/1ns
`default_nettype none
`include "pado_defs.svh"

module pado_top #(
  parameter int RES_BITS = `PADO_RES_BITS,
  parameter int STAGES = `PADO_STAGES,
  parameter int FIFO_DEPTH = `PADO_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic conv_clk_pin,
  input wire logic [RES_BITS-1:0] ain_sample,
  input wire logic msb_flip_select,
  input wire logic float_select,
  output logic [RES_BITS-1:0] data_out,
  output logic data_oe_n,
  output logic track_phase,
  output logic hold_phase
);

  localparam int DW = `PADO_DIGIT_BITS;
  localparam int SW = `PADO_STAMP_BITS;
  localparam int WW = SW + RES_BITS;

  initial
  begin
    if (RES_BITS != `PADO_RES_BITS || STAGES != `PADO_STAGES)
      $error("pado_top: only a 10-bit word from nine stages is supported");
  end

  // ==========================================
  // reset release
  logic rst_a_ff;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_a_ff <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_a_ff <= 1'b1;
      rst_n <= rst_a_ff;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================
  // pin synchronisers
  logic conv_lvl;
  logic [RES_BITS-1:0] ain_lvl;
  logic [1:0] sel_lvl;

  pado_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_sync_clk (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(conv_clk_pin),
    .level(conv_lvl)
  );

  // analog value presented as a digital level; held while it settles
  pado_sync #(.WIDTH(RES_BITS), .RESET_VAL('0)) u_sync_ain (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in(ain_sample),
    .level(ain_lvl)
  );

  // reset value zero stands for the internal pull-downs
  pado_sync #(.WIDTH(2), .RESET_VAL(2'h0)) u_sync_sel (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({msb_flip_select, float_select}),
    .level(sel_lvl)
  );

  // ==========================================
  // convert clock edges and two-phase switching
  logic conv_d_ff;
  logic track_ff;
  logic hold_ff;
  logic nxt_track;
  logic nxt_hold;
  logic rise_ev;
  logic fall_ev;
  logic sub_en;
  logic [SW-1:0] edge_cnt_ff;
  logic [SW-1:0] nxt_edge;

  always_comb
  begin
    rise_ev = conv_lvl && !conv_d_ff;
    fall_ev = !conv_lvl && conv_d_ff;
    sub_en = rise_ev || fall_ev;
    nxt_edge = sub_en ? edge_cnt_ff + 1'b1 : edge_cnt_ff;
    // one dead cycle after each edge keeps the phases apart
    nxt_track = !conv_lvl && !conv_d_ff;
    nxt_hold = conv_lvl && conv_d_ff;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_d_ff <= 1'b0;
      track_ff <= 1'b0;
      hold_ff <= 1'b0;
      edge_cnt_ff <= '0;
    end
    else
    begin
      conv_d_ff <= conv_lvl;
      track_ff <= nxt_track;
      hold_ff <= nxt_hold;
      edge_cnt_ff <= nxt_edge;
    end
  end

  assign track_phase = track_ff;
  assign hold_phase = hold_ff;

  a_phase_apart: assert property (!(track_ff && hold_ff))
    else $error("track and hold phases overlap");
  a_phase_gap: assert property ($fell(hold_ff) |-> !track_ff ##1 track_ff || hold_ff)
    else $error("track phase began without a dead cycle");

  // ==========================================
  // stage arithmetic
  function automatic pado_pkg::pado_slot_t stage_step(input pado_pkg::pado_slot_t s, input int idx);
    pado_pkg::pado_slot_t r;
    logic [1:0] d;
    logic [RES_BITS:0] two_r;
    r = s;
    two_r = {s.resid, 1'b0};
    if (idx == STAGES - 1)
      d = s.resid[`PADO_FLASH_SHIFT +: DW];
    else if (s.resid < `PADO_QTR_FS)
      d = `PADO_DIGIT_ZERO;
    else if (s.resid < `PADO_3QTR_FS)
    begin
      d = `PADO_DIGIT_MID;
      two_r = two_r - `PADO_HALF_FS;
    end
    else
    begin
      d = `PADO_DIGIT_HIGH;
      two_r = two_r - `PADO_FULL_FS;
    end
    r.resid = two_r[RES_BITS-1:0];
    r.digits[idx*DW +: DW] = d;
    return r;
  endfunction : stage_step

  // overlapping digits summed: redundancy absorbs comparator slop
  function automatic logic [RES_BITS-1:0] correct(input logic [STAGES*DW-1:0] dg);
    logic [RES_BITS:0] acc;
    acc = '0;
    for (int i = 0; i < STAGES - 1; i++)
      acc = acc + ({{(RES_BITS-1){1'b0}}, dg[i*DW +: DW]} << (STAGES - 1 - i));
    acc = acc + {{(RES_BITS-1){1'b0}}, dg[(STAGES-1)*DW +: DW]};
    return acc[RES_BITS-1:0];
  endfunction : correct

  // ==========================================
  // sample slot and nine stage slots
  pado_pkg::pado_slot_t slot_ff [STAGES+1];
  pado_pkg::pado_slot_t nxt_slot [STAGES+1];
  logic [STAGES:0] slot_valid;
  logic fifo_in_ready;
  logic advance;

  // a full buffer freezes the pipeline rather than losing a word
  assign advance = sub_en && fifo_in_ready;

  always_comb
  begin
    nxt_slot[0] = slot_ff[0];
    if (advance)
    begin
      nxt_slot[0].valid = rise_ev;
      nxt_slot[0].stamp = nxt_edge;
      nxt_slot[0].sample = ain_lvl;
      nxt_slot[0].resid = ain_lvl;
      nxt_slot[0].digits = '0;
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi <= STAGES; gi++)
    begin : g_stage
      always_comb
      begin
        nxt_slot[gi] = slot_ff[gi];
        if (advance)
          nxt_slot[gi] = stage_step(slot_ff[gi-1], gi - 1);
      end
    end
    for (gi = 0; gi <= STAGES; gi++)
    begin : g_valid
      assign slot_valid[gi] = slot_ff[gi].valid;
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i <= STAGES; i++)
        slot_ff[i] <= '0;
    end
    else
    begin
      for (int i = 0; i <= STAGES; i++)
        slot_ff[i] <= nxt_slot[i];
    end
  end

  a_stage_walk: assert property (advance && slot_ff[0].valid |=> slot_ff[1].valid ##0
    slot_ff[1].stamp == $past(slot_ff[0].stamp))
    else $error("sample did not move into the first stage");

  // ==========================================
  // correction and buffering
  pado_pkg::pado_word_t push_word;
  pado_pkg::pado_word_t head_word;
  logic push_valid;
  logic head_valid;
  logic head_take;

  always_comb
  begin
    push_valid = advance && slot_ff[STAGES].valid;
    push_word.stamp = slot_ff[STAGES].stamp;
    push_word.code = correct(slot_ff[STAGES].digits);
    // launch only on a falling edge, exactly 13 half cycles after sampling
    head_take = fall_ev && (SW'(nxt_edge - head_word.stamp) == `PADO_LAT_HALF_CYCLES);
  end

  pado_fifo #(.WIDTH(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(head_valid),
    .out_ready(head_take),
    .out_data(head_word)
  );

  a_correct_exact: assert property (push_valid |-> push_word.code == slot_ff[STAGES].sample)
    else $error("corrected word differs from the held sample");

  // ==========================================
  // static configuration, taken only while idle
  pado_pkg::pado_cfg_t cfg_ff;
  pado_pkg::pado_cfg_t nxt_cfg;
  logic busy;

  always_comb
  begin
    busy = (|slot_valid) || head_valid;
    nxt_cfg = cfg_ff;
    if (!busy)
    begin
      nxt_cfg.msb_flip = sel_lvl[1];
      nxt_cfg.float_out = sel_lvl[0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_ff <= '0;
    else
      cfg_ff <= nxt_cfg;
  end

  a_cfg_static: assert property (busy |=> $stable(cfg_ff))
    else $error("configuration changed during conversion");

  // ==========================================
  // output word
  logic [RES_BITS-1:0] data_ff;
  logic [RES_BITS-1:0] nxt_data;
  logic [SW-1:0] out_stamp_ff;
  logic [SW-1:0] nxt_out_stamp;
  logic out_upd_ff;
  logic head_pop;

  always_comb
  begin
    head_pop = head_take && head_valid;
    nxt_data = data_ff;
    nxt_out_stamp = out_stamp_ff;
    if (head_pop)
    begin
      nxt_out_stamp = head_word.stamp;
      nxt_data = head_word.code;
      if (cfg_ff.msb_flip)
        nxt_data[RES_BITS-1] = ~head_word.code[RES_BITS-1];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_ff <= '0;
      out_stamp_ff <= '0;
      out_upd_ff <= 1'b0;
    end
    else
    begin
      data_ff <= nxt_data;
      out_stamp_ff <= nxt_out_stamp;
      out_upd_ff <= head_pop;
    end
  end

  assign data_out = data_ff;
  // test aid only, not for bus sharing
  assign data_oe_n = cfg_ff.float_out;

  a_out_latency: assert property (out_upd_ff |-> SW'(edge_cnt_ff - out_stamp_ff) == `PADO_LAT_HALF_CYCLES)
    else $error("output word latency is not 6.5 convert cycles");
  a_code_offset: assert property (head_pop && !cfg_ff.msb_flip |=> data_ff == $past(head_word.code))
    else $error("offset binary word wrong");
  a_code_twos: assert property (head_pop && cfg_ff.msb_flip |=>
    data_ff == {~$past(head_word.code[RES_BITS-1]), $past(head_word.code[RES_BITS-2:0])})
    else $error("two's complement word wrong");
  a_word_stable: assert property (!head_pop |=> $stable(data_ff))
    else $error("output word changed between updates");
  a_float_pins: assert property (!busy && sel_lvl[0] |=> data_oe_n)
    else $error("outputs not floated with float select high");

endmodule : pado_top
`default_nettype wire

// file: verification/pado_capture_model.sv
// capture logic model: makes the convert clock, presents input codes, latches words
// assumes sys_clk from the bench and a resolved data bus
`timescale 1ns/1ns
`default_nettype none

module pado_capture_model #(
  parameter int HALF = 10
) (
  input wire logic sys_clk,
  input wire logic run,
  input wire logic [9:0] data_bus,
  input wire logic track_phase,
  input wire logic hold_phase,
  output logic conv_clk_pin,
  output logic [9:0] ain_sample
);
  logic [9:0] codes [0:31];
  logic [9:0] rise_word [0:31];
  logic [9:0] fall_word [0:31];
  int n_rise;
  int phase_bad;

  // ==========================================
  // convert clock, still while idle
  initial
  begin
    conv_clk_pin = 1'b0;
    ain_sample = 10'h000;
    n_rise = 0;
    phase_bad = 0;
  end

  always
  begin
    @(posedge sys_clk);
    if (run)
    begin
      #1 ain_sample = codes[n_rise[4:0]];
      repeat (HALF - 1) @(posedge sys_clk);
      #1 if (!(track_phase && !hold_phase)) phase_bad++;
      // latch on our own rising edge, word settled mid-period
      rise_word[n_rise[4:0]] = data_bus;
      conv_clk_pin = 1'b1;
      repeat (HALF) @(posedge sys_clk);
      #1 if (!(hold_phase && !track_phase)) phase_bad++;
      fall_word[n_rise[4:0]] = data_bus;
      n_rise++;
      conv_clk_pin = 1'b0;
    end
  end
endmodule : pado_capture_model
`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench of the converter output stage
// assumes pado_top and the capture model; select pins change at reset, except the flip pin moved mid-run in t_flip_held
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic sys_clk;
  logic reset_n;
  logic msb_flip_select;
  logic float_select;
  logic run;
  logic conv_clk_pin;
  logic [9:0] ain_sample;
  logic [9:0] data_out;
  logic data_oe_n;
  logic track_phase;
  logic hold_phase;
  wire [9:0] data_bus = data_oe_n ? 10'hZZZ : data_out;
  int n_mismatch;
  int compares;
  logic [9:0] tbl [0:7];

  pado_top pado_top_inst (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .conv_clk_pin(conv_clk_pin),
    .ain_sample(ain_sample),
    .msb_flip_select(msb_flip_select),
    .float_select(float_select),
    .data_out(data_out),
    .data_oe_n(data_oe_n),
    .track_phase(track_phase),
    .hold_phase(hold_phase)
  );

  pado_capture_model pado_capture_model_inst (
    .sys_clk(sys_clk),
    .run(run),
    .data_bus(data_bus),
    .track_phase(track_phase),
    .hold_phase(hold_phase),
    .conv_clk_pin(conv_clk_pin),
    .ain_sample(ain_sample)
  );

  // ==========================================
  // clock and shared tasks
  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;

  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic do_reset(input logic flip, input logic flt);
    @(posedge sys_clk);
    #1 reset_n = 1'b0;
    msb_flip_select = flip;
    float_select = flt;
    repeat (10) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    repeat (20) @(posedge sys_clk);
  endtask : do_reset

  // feeds the table then idle codes; 7 extra periods drain the pipeline
  task automatic run_codes(input int n);
    int guard;
    for (int i = 0; i < 32; i++)
      pado_capture_model_inst.codes[i] = (i < 8) ? tbl[i] : 10'h000;
    pado_capture_model_inst.n_rise = 0;
    pado_capture_model_inst.phase_bad = 0;
    guard = 0;
    run = 1'b1;
    while (pado_capture_model_inst.n_rise < n && guard < 2000)
    begin
      @(posedge sys_clk);
      #2 guard++;
    end
    run = 1'b0;
    if (guard >= 2000)
      check(10'h001, 10'h000, "convert run hung");
  endtask : run_codes

  // sample i shows up at the capture edge 7 rises later
  task automatic judge_words(input logic flip, input string name);
    for (int i = 0; i < 8; i++)
      check(pado_capture_model_inst.rise_word[i + 7], {tbl[i][9] ^ flip, tbl[i][8:0]}, name);
    for (int k = 7; k < 15; k++)
      check(pado_capture_model_inst.fall_word[k], pado_capture_model_inst.rise_word[k], "word moved");
    check(10'(pado_capture_model_inst.phase_bad), 10'h000, "phase overlap");
  endtask : judge_words

  // ==========================================
  // scenarios
  task automatic t_offset_binary();
    do_reset(1'b0, 1'b0);
    run_codes(15);
    judge_words(1'b0, "offset binary");
    $display("test offset_binary done");
  endtask : t_offset_binary

  task automatic t_twos_comp();
    do_reset(1'b1, 1'b0);
    run_codes(15);
    judge_words(1'b1, "twos complement");
    $display("test twos_comp done");
  endtask : t_twos_comp

  // flip pin moved mid-run: the running coding must stay
  task automatic t_flip_held();
    do_reset(1'b0, 1'b0);
    fork
      run_codes(15);
      begin
        repeat (60) @(posedge sys_clk);
        #1 msb_flip_select = 1'b1;
      end
    join
    judge_words(1'b0, "flip held off");
    $display("test flip_held done");
  endtask : t_flip_held

  task automatic t_float();
    do_reset(1'b0, 1'b1);
    check({9'h000, data_oe_n}, 10'h001, "oe not floated");
    check(data_bus, 10'hZZZ, "bus not floated");
    do_reset(1'b0, 1'b0);
    check({9'h000, data_oe_n}, 10'h000, "oe not driving");
    check(data_bus, 10'h000, "bus not driven");
    $display("test float done");
  endtask : t_float

  // ==========================================
  // sequence, watchdog and verdict
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  initial
  begin
    reset_n = 1'b0;
    msb_flip_select = 1'b0;
    float_select = 1'b0;
    run = 1'b0;
    n_mismatch = 0;
    compares = 0;
    // full scale first: all ones in offset binary
    tbl = '{10'h3FF, 10'h000, 10'h200, 10'h1FF, 10'h100, 10'h300, 10'h155, 10'h2AA};
    t_float();
    t_offset_binary();
    t_twos_comp();
    t_flip_held();
    wrap_up();
  end

  // three runs of 15 periods take about 900 cycles
  initial
  begin
    #(20 * 20000);
    n_mismatch++;
    $display("BAD t=%0t watchdog expired", $time);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
